//--- design/anc_regs_defines.vh
// Purpose: Register indices, field positions and reset values of the
//          ancillary insertion and format status register bank.
// Assumes: Byte address on the bus is four times the register index.
// Notes:   Definitions only.
`ifndef ANC_REGS_DEFINES_VH
`define ANC_REGS_DEFINES_VH

// =====================================================================
// Register indices
`define IDX_PID_OUT_S2_B34 10'h00D
`define IDX_PID_IN_S1_B12 10'h00E
`define IDX_PID_IN_S1_B34 10'h00F
`define IDX_PID_IN_S2_B12 10'h010
`define IDX_PID_IN_S2_B34 10'h011
`define IDX_FRAME_LINES 10'h012
`define IDX_LINE_WORDS 10'h013
`define IDX_ACTIVE_WORDS 10'h014
`define IDX_ACTIVE_LINES 10'h015
`define IDX_INSERT_STATUS 10'h024
`define IDX_MODE_LINE_ONE 10'h025
`define IDX_LINE_ONE_PLACE 10'h026
`define IDX_LINE_TWO_SEL 10'h027
`define IDX_LINE_TWO_PLACE 10'h028
`define IDX_LINE_THREE_SEL 10'h029
`define IDX_LINE_THREE_PLACE 10'h02A
`define IDX_IRQ_MASK 10'h02E

// =====================================================================
// Field positions
`define BIT_LAYOUT_SEL 11
`define BIT_REGION_SEL 15
`define BIT_STREAM_SEL 14
`define BIT_INCOMPLETE 1
`define BIT_COLLISION 0

// =====================================================================
// Reset values
`define RST_BYTE 8'h00
`define RST_LINE_NUM 11'h000
`define RST_WORD_COUNT 10'h000
`define RST_STATUS 2'h0

`endif

//--- design/anc_line_slot.v
// Purpose: Placement settings of one target line: region, stream and
//          word count, written with byte lanes.
// Assumes: Write strobe is qualified by the bus slave.
// Notes:   Instantiated once per target line.
`timescale 1ns/10ps
`include "anc_regs_defines.vh"

module anc_line_slot (
    // Clock and synchronised reset
    input wire i_clk_sys,
    input wire i_rst_n,
    // Write side
    input wire i_wr,
    input wire [1:0] i_sel,
    input wire [15:0] i_data,
    // Settings and read view
    output wire o_region_sel,
    output wire o_stream_sel,
    output wire [9:0] o_word_count,
    output wire [15:0] o_view
);

    reg region_ff;
    reg stream_ff;
    reg [9:0] count_ff;

    // =================================================================
    // Storage
    // High byte holds region and stream, low byte the count's low bits.
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            region_ff <= 1'b0;
            stream_ff <= 1'b0;
            count_ff <= `RST_WORD_COUNT;
        end else if (i_wr) begin
            if (i_sel[1]) begin
                region_ff <= i_data[`BIT_REGION_SEL]; // RULE14
                stream_ff <= i_data[`BIT_STREAM_SEL]; // RULE15
                count_ff[9:8] <= i_data[9:8]; // RULE16
            end
            if (i_sel[0]) begin
                count_ff[7:0] <= i_data[7:0]; // RULE16
            end
        end
    end

    // Reserved bits 13 to 10 always read as zero.
    assign o_view = {region_ff, stream_ff, 4'h0, count_ff}; // RULE17
    assign o_region_sel = region_ff;
    assign o_stream_sel = stream_ff;
    assign o_word_count = count_ff;

endmodule // anc_line_slot

//--- design/anc_insert_and_format_status_regs.v
// Purpose: Host register bank for payload identifier bytes, detected
//          raster geometry and ancillary insertion control and status.
// Assumes: Wishbone classic slave, 32-bit data, registers in the low
//          16 bits, byte address equal to four times the index.
// Notes:   Event flags are sticky and clear on read; one level
//          interrupt gathers the unmasked ones.
`timescale 1ns/10ps
`include "anc_regs_defines.vh"

// How it works
// RULE1: Bytes four and three of stream two's outgoing identifier sit in one writable register.
// RULE2: Stream one's four extracted identifier bytes read back in two read-only registers.
// RULE3: Stream two's four extracted identifier bytes read back in two read-only registers.
// RULE4: Detected lines per frame read as an eleven-bit field that resets to zero.
// RULE5: Detected words per line read as a fourteen-bit field that resets to zero.
// RULE6: Detected active words per line read as a thirteen-bit field that resets to zero.
// RULE7: Detected active lines read as an eleven-bit field that resets to zero.
// RULE8: A status bit reports a packet that could not be inserted whole.
// RULE9: A status bit reports a packet memory location read and written in one cycle.
// RULE10: A writable layout bit picks concatenated (high) or separate (low) lines, reset low.
// RULE11: A writable eleven-bit field names the first packet's line, reset zero.
// RULE12: A writable eleven-bit field names the second packet's line in separate mode.
// RULE13: A writable eleven-bit field names the third packet's line in separate mode.
// RULE14: A per-line region bit selects vertical (high) or horizontal (low) space.
// RULE15: A per-line stream bit selects chroma (high) or luma (low).
// RULE16: A per-line ten-bit field gives the exact number of packet words.
// RULE17: Reserved bits and addresses read zero and writes to them or to status are ignored.
module anc_insert_and_format_status_regs (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_resetn,
    // Wishbone classic slave
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [11:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output wire [31:0] o_wb_dat,
    output wire o_wb_ack,
    // Extracted identifier bytes from the video path
    input wire [7:0] i_pid_in_s1_b1,
    input wire [7:0] i_pid_in_s1_b2,
    input wire [7:0] i_pid_in_s1_b3,
    input wire [7:0] i_pid_in_s1_b4,
    input wire [7:0] i_pid_in_s2_b1,
    input wire [7:0] i_pid_in_s2_b2,
    input wire [7:0] i_pid_in_s2_b3,
    input wire [7:0] i_pid_in_s2_b4,
    // Detected raster geometry
    input wire [10:0] i_frame_lines,
    input wire [13:0] i_line_words,
    input wire [12:0] i_active_words,
    input wire [10:0] i_active_lines,
    // Insertion engine events, one-cycle pulses
    input wire i_insert_incomplete,
    input wire i_ram_collision,
    // Outgoing identifier bytes for stream two
    output wire [7:0] o_pid_out_s2_b4,
    output wire [7:0] o_pid_out_s2_b3,
    // Insertion control
    output wire o_insert_layout_select,
    output wire [10:0] o_line_one_number,
    output wire [10:0] o_line_two_number,
    output wire [10:0] o_line_three_number,
    output wire o_line_one_region_sel,
    output wire o_line_one_stream_sel,
    output wire [9:0] o_line_one_word_count,
    output wire o_line_two_region_sel,
    output wire o_line_two_stream_sel,
    output wire [9:0] o_line_two_word_count,
    output wire o_line_three_region_sel,
    output wire o_line_three_stream_sel,
    output wire [9:0] o_line_three_word_count,
    // Interrupt
    output wire o_irq
);

    // =================================================================
    // Declarations
    // Flip-flops, plus the combinational nxt_rdata and nxt_status.
    reg rst_meta_ff;
    reg rst_n_ff;
    reg ack_ff;
    reg [15:0] rdata_ff;
    reg [7:0] pid_b4_ff;
    reg [7:0] pid_b3_ff;
    reg layout_ff;
    reg [10:0] line_one_ff;
    reg [10:0] line_two_ff;
    reg [10:0] line_three_ff;
    reg [1:0] status_ff;
    reg [1:0] mask_ff;
    reg [15:0] nxt_rdata;
    reg [1:0] nxt_status;
    // Nets.
    wire [9:0] idx;
    wire req;
    wire wr_en;
    wire rd_done;
    wire [15:0] wdata;
    wire [1:0] lanes;
    wire [15:0] view_one;
    wire [15:0] view_two;
    wire [15:0] view_three;
    wire [1:0] events;
    wire status_clr;

    // =================================================================
    // Reset release
    // Assertion is immediate; release is retimed to avoid recovery
    // hazards across the whole bank.
    // Everything else resets from the retimed copy.
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // =================================================================
    // Bus decode
    // The index drops the two byte-offset bits of the address.
    // Indices beyond the map answer zero.
    assign idx = i_wb_adr[11:2];
    assign req = i_wb_cyc & i_wb_stb;
    // Writes and read side effects commit on the acknowledge edge only.
    assign wr_en = req & i_wb_we & ack_ff;
    assign rd_done = req & ~i_wb_we & ack_ff;
    // Only the low half carries register bits;
    // lanes three and two are ignored.
    assign wdata = i_wb_dat[15:0];
    assign lanes = i_wb_sel[1:0];

    // One-cycle acknowledge; it drops after one cycle so back-to-back
    // requests see a fresh answer every second cycle.
    always @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    assign o_wb_ack = ack_ff;
    assign o_wb_dat = {16'h0000, rdata_ff};

    // =================================================================
    // Writable control registers
    // Each lane commits alone.
    always @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pid_b4_ff <= `RST_BYTE;
            pid_b3_ff <= `RST_BYTE;
            layout_ff <= 1'b0;
            line_one_ff <= `RST_LINE_NUM;
            line_two_ff <= `RST_LINE_NUM;
            line_three_ff <= `RST_LINE_NUM;
            mask_ff <= 2'h0;
        end else if (wr_en) begin
            case (idx)
                `IDX_PID_OUT_S2_B34: begin
                    if (lanes[1]) begin
                        pid_b4_ff <= wdata[15:8]; // RULE1
                    end
                    if (lanes[0]) begin
                        pid_b3_ff <= wdata[7:0]; // RULE1
                    end
                end
                `IDX_MODE_LINE_ONE: begin
                    if (lanes[1]) begin
                        layout_ff <= wdata[`BIT_LAYOUT_SEL]; // RULE10
                        line_one_ff[10:8] <= wdata[10:8]; // RULE11
                    end
                    if (lanes[0]) begin
                        line_one_ff[7:0] <= wdata[7:0]; // RULE11
                    end
                end
                `IDX_LINE_TWO_SEL: begin
                    if (lanes[1]) begin
                        line_two_ff[10:8] <= wdata[10:8]; // RULE12
                    end
                    if (lanes[0]) begin
                        line_two_ff[7:0] <= wdata[7:0]; // RULE12
                    end
                end
                `IDX_LINE_THREE_SEL: begin
                    if (lanes[1]) begin
                        line_three_ff[10:8] <= wdata[10:8]; // RULE13
                    end
                    if (lanes[0]) begin
                        line_three_ff[7:0] <= wdata[7:0]; // RULE13
                    end
                end
                `IDX_IRQ_MASK: begin
                    // Mask bits use the low lane.
                    if (lanes[0]) begin
                        mask_ff <= wdata[1:0];
                    end
                end
                default: begin
                    // Status, read-only and reserved words ignore writes.
                    mask_ff <= mask_ff; // RULE17
                end
            endcase
        end
    end

    // =================================================================
    // Per-line placement settings
    // Each slot takes its own write, decoded here; the region, stream and count
    // steer where and how much the engine inserts.
    // One module serves all three slots;
    // only the decoded write differs.
    anc_line_slot u_slot_one (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n_ff),
        .i_wr(wr_en & (idx == `IDX_LINE_ONE_PLACE)),
        .i_sel(lanes),
        .i_data(wdata),
        .o_region_sel(o_line_one_region_sel),
        .o_stream_sel(o_line_one_stream_sel),
        .o_word_count(o_line_one_word_count),
        .o_view(view_one)
    );

    anc_line_slot u_slot_two (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n_ff),
        .i_wr(wr_en & (idx == `IDX_LINE_TWO_PLACE)),
        .i_sel(lanes),
        .i_data(wdata),
        .o_region_sel(o_line_two_region_sel),
        .o_stream_sel(o_line_two_stream_sel),
        .o_word_count(o_line_two_word_count),
        .o_view(view_two)
    );

    anc_line_slot u_slot_three (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n_ff),
        .i_wr(wr_en & (idx == `IDX_LINE_THREE_PLACE)),
        .i_sel(lanes),
        .i_data(wdata),
        .o_region_sel(o_line_three_region_sel),
        .o_stream_sel(o_line_three_stream_sel),
        .o_word_count(o_line_three_word_count),
        .o_view(view_three)
    );

    // =================================================================
    // Sticky event flags
    // A read of the status word clears it, but an event landing in the
    // same cycle survives the clear so no event is ever lost.
    // Events are one-cycle pulses on this clock.
    assign events[`BIT_INCOMPLETE] = i_insert_incomplete; // RULE8
    assign events[`BIT_COLLISION] = i_ram_collision; // RULE9
    // The ack qualifies the clear, so it acts once.
    assign status_clr = rd_done & (idx == `IDX_INSERT_STATUS);

    always @* begin
        nxt_status = status_ff;
        if (status_clr) begin
            // Clear only bits the read returned; a flag set on
            // the capture edge was never seen by software.
            nxt_status = status_ff & ~rdata_ff[1:0];
        end
        nxt_status = nxt_status | events; // RULE8 RULE9
    end

    always @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            status_ff <= `RST_STATUS;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // Level interrupt while any unmasked flag stands.
    // Both inputs are flip-flops, so no retiming.
    assign o_irq = |(status_ff & mask_ff);

    // =================================================================
    // Read multiplexer
    // Geometry and extracted bytes are sampled live from the video
    // path, which runs on this same clock.
    // Unmapped indices read zero.
    always @* begin
        nxt_rdata = 16'h0000;
        case (idx)
            `IDX_PID_OUT_S2_B34: nxt_rdata = {pid_b4_ff, pid_b3_ff};
            `IDX_PID_IN_S1_B12: nxt_rdata = {i_pid_in_s1_b2, i_pid_in_s1_b1}; // RULE2
            `IDX_PID_IN_S1_B34: nxt_rdata = {i_pid_in_s1_b4, i_pid_in_s1_b3}; // RULE2
            `IDX_PID_IN_S2_B12: nxt_rdata = {i_pid_in_s2_b2, i_pid_in_s2_b1}; // RULE3
            `IDX_PID_IN_S2_B34: nxt_rdata = {i_pid_in_s2_b4, i_pid_in_s2_b3}; // RULE3
            `IDX_FRAME_LINES: nxt_rdata = {5'h00, i_frame_lines}; // RULE4
            `IDX_LINE_WORDS: nxt_rdata = {2'h0, i_line_words}; // RULE5
            `IDX_ACTIVE_WORDS: nxt_rdata = {3'h0, i_active_words}; // RULE6
            `IDX_ACTIVE_LINES: nxt_rdata = {5'h00, i_active_lines}; // RULE7
            `IDX_INSERT_STATUS: nxt_rdata = {14'h0000, status_ff}; // RULE8 RULE9
            `IDX_MODE_LINE_ONE: nxt_rdata = {4'h0, layout_ff, line_one_ff};
            `IDX_LINE_ONE_PLACE: nxt_rdata = view_one;
            `IDX_LINE_TWO_SEL: nxt_rdata = {5'h00, line_two_ff};
            `IDX_LINE_TWO_PLACE: nxt_rdata = view_two;
            `IDX_LINE_THREE_SEL: nxt_rdata = {5'h00, line_three_ff};
            `IDX_LINE_THREE_PLACE: nxt_rdata = view_three;
            `IDX_IRQ_MASK: nxt_rdata = {14'h0000, mask_ff};
            default: nxt_rdata = 16'h0000; // RULE17
        endcase
    end

    // Read data is captured with the acknowledge and held until the
    // next answer; writes answer with zero data.
    // Taking data at the take edge samples live
    // inputs as they stood when asked.
    always @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rdata_ff <= 16'h0000;
        end else if (req & ~ack_ff) begin
            if (i_wb_we) begin
                rdata_ff <= 16'h0000;
            end else begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // =================================================================
    // Control outputs to the insertion engine
    // Straight from flip-flops: no glitches
    // while software rewrites a word.
    assign o_pid_out_s2_b4 = pid_b4_ff; // RULE1
    assign o_pid_out_s2_b3 = pid_b3_ff; // RULE1
    assign o_insert_layout_select = layout_ff; // RULE10
    assign o_line_one_number = line_one_ff; // RULE11
    assign o_line_two_number = line_two_ff; // RULE12
    assign o_line_three_number = line_three_ff; // RULE13

endmodule // anc_insert_and_format_status_regs

//--- verif/anc_regs_checker.sv
// Purpose: Timing checks on the ports of the insertion register bank.
// Assumes: Bound to the top module; classic single cycles from the master.
// Notes:   Write effects are checked two edges after the request is taken.
`timescale 1ns/10ps
`include "anc_regs_defines.vh"

// =====================================================================
// Checker
module anc_regs_checker (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_resetn,
    // Bus
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [11:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    input wire [31:0] o_wb_dat,
    input wire o_wb_ack,
    // Watched block signals
    input wire [10:0] i_frame_lines,
    input wire i_insert_incomplete,
    input wire i_ram_collision,
    input wire [7:0] o_pid_out_s2_b4,
    input wire [7:0] o_pid_out_s2_b3,
    input wire o_insert_layout_select,
    input wire [10:0] o_line_one_number,
    input wire o_line_one_region_sel,
    input wire o_line_one_stream_sel,
    input wire [9:0] o_line_one_word_count,
    input wire o_irq
);
    // A request is taken only while no answer stands, so a held strobe is not counted twice.
    wire take = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire full = take && i_wb_we && (i_wb_sel[1:0] == 2'b11);
    wire [9:0] idx = i_wb_adr[11:2];

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    ack_after_req_a: assert property (take |=> o_wb_ack) else $error("ack late");
    ack_single_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
    ack_cause_a: assert property (o_wb_ack |-> $past(take)) else $error("ack unasked");
    upper_zero_a: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0000)
        else $error("upper half set");
    pid_write_a: assert property (full && idx == `IDX_PID_OUT_S2_B34 |->
        ##2 {o_pid_out_s2_b4, o_pid_out_s2_b3} == $past(i_wb_dat[15:0], 2))
        else $error("outgoing bytes wrong");
    mode_write_a: assert property (full && idx == `IDX_MODE_LINE_ONE |->
        ##2 {o_insert_layout_select, o_line_one_number} == $past(i_wb_dat[11:0], 2))
        else $error("mode or line wrong");
    place_write_a: assert property (full && idx == `IDX_LINE_ONE_PLACE |->
        ##2 {o_line_one_region_sel, o_line_one_stream_sel, o_line_one_word_count} ==
        {$past(i_wb_dat[15:14], 2), $past(i_wb_dat[9:0], 2)})
        else $error("placement wrong");
    frame_read_a: assert property (take && !i_wb_we && idx == `IDX_FRAME_LINES |=>
        o_wb_dat == {21'h000000, $past(i_frame_lines)}) else $error("frame lines wrong");
    irq_rise_a: assert property ($rose(o_irq) |->
        $past(i_insert_incomplete || i_ram_collision || (i_wb_cyc && i_wb_we)))
        else $error("irq without cause");
    irq_fall_a: assert property ($fell(o_irq) |-> $past(o_wb_ack))
        else $error("irq dropped alone");
endmodule // anc_regs_checker

bind anc_insert_and_format_status_regs anc_regs_checker u_chk (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_frame_lines(i_frame_lines),
    .i_insert_incomplete(i_insert_incomplete), .i_ram_collision(i_ram_collision),
    .o_pid_out_s2_b4(o_pid_out_s2_b4), .o_pid_out_s2_b3(o_pid_out_s2_b3),
    .o_insert_layout_select(o_insert_layout_select), .o_line_one_number(o_line_one_number),
    .o_line_one_region_sel(o_line_one_region_sel),
    .o_line_one_stream_sel(o_line_one_stream_sel),
    .o_line_one_word_count(o_line_one_word_count), .o_irq(o_irq));

//--- verif/anc_insert_and_format_status_regs_tb_top.sv
// Purpose: Self-checking bench for the insertion register bank.
// Assumes: Model of registers kept in the bench, compared at every read.
// Notes:   Random traffic favours writable places so byte lanes get exercised.
`timescale 1ns/10ps
`include "anc_regs_defines.vh"

// =====================================================================
// Bench
module anc_insert_and_format_status_regs_tb_top;
    logic clk, resetn, cyc, stb, we, inc, col;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, seed, v;
    logic [7:0] pa [0:7];
    logic [10:0] fl, al;
    logic [13:0] lw;
    logic [12:0] aw;
    logic [15:0] m [0:63];
    logic [1:0] stat;
    wire [31:0] rd;
    wire [7:0] b4, b3;
    wire ack, lay, r1, s1, r2, s2, r3, s3, irq;
    wire [10:0] l1, l2, l3;
    wire [9:0] c1, c2, c3;
    int err_count, tests_run, k, j;
    int wl [0:7] = '{13, 37, 38, 39, 40, 41, 42, 46};

    anc_insert_and_format_status_regs dut (.i_clk_sys(clk), .i_resetn(resetn),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(dat), .o_wb_dat(rd), .o_wb_ack(ack), .i_pid_in_s1_b1(pa[0]),
        .i_pid_in_s1_b2(pa[1]), .i_pid_in_s1_b3(pa[2]), .i_pid_in_s1_b4(pa[3]),
        .i_pid_in_s2_b1(pa[4]), .i_pid_in_s2_b2(pa[5]), .i_pid_in_s2_b3(pa[6]),
        .i_pid_in_s2_b4(pa[7]), .i_frame_lines(fl), .i_line_words(lw),
        .i_active_words(aw), .i_active_lines(al), .i_insert_incomplete(inc),
        .i_ram_collision(col), .o_pid_out_s2_b4(b4), .o_pid_out_s2_b3(b3),
        .o_insert_layout_select(lay), .o_line_one_number(l1), .o_line_two_number(l2),
        .o_line_three_number(l3), .o_line_one_region_sel(r1), .o_line_one_stream_sel(s1),
        .o_line_one_word_count(c1), .o_line_two_region_sel(r2), .o_line_two_stream_sel(s2),
        .o_line_two_word_count(c2), .o_line_three_region_sel(r3),
        .o_line_three_stream_sel(s3), .o_line_three_word_count(c3), .o_irq(irq));

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Bits that software may change in each register; all else must hold.
    function automatic logic [15:0] wmask(input logic [9:0] i);
        case (i)
            `IDX_PID_OUT_S2_B34: wmask = 16'hFFFF;
            `IDX_MODE_LINE_ONE: wmask = 16'h0FFF;
            `IDX_LINE_TWO_SEL, `IDX_LINE_THREE_SEL: wmask = 16'h07FF;
            `IDX_LINE_ONE_PLACE, `IDX_LINE_TWO_PLACE, `IDX_LINE_THREE_PLACE: wmask = 16'hC3FF;
            `IDX_IRQ_MASK: wmask = 16'h0003;
            default: wmask = 16'h0000;
        endcase
    endfunction

    // Expected read value; live inputs are sampled when the read is taken.
    function automatic logic [15:0] expv(input logic [9:0] i);
        case (i)
            `IDX_PID_IN_S1_B12: expv = {pa[1], pa[0]};
            `IDX_PID_IN_S1_B34: expv = {pa[3], pa[2]};
            `IDX_PID_IN_S2_B12: expv = {pa[5], pa[4]};
            `IDX_PID_IN_S2_B34: expv = {pa[7], pa[6]};
            `IDX_FRAME_LINES: expv = {5'h00, fl};
            `IDX_LINE_WORDS: expv = {2'h0, lw};
            `IDX_ACTIVE_WORDS: expv = {3'h0, aw};
            `IDX_ACTIVE_LINES: expv = {5'h00, al};
            `IDX_INSERT_STATUS: expv = {14'h0000, stat};
            default: expv = (i < 64) ? m[i[5:0]] : 16'h0000;
        endcase
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One classic cycle; entered just after a rising edge, leaves one idle cycle.
    task automatic wb(input logic w, input logic [9:0] i, input logic [15:0] d,
                      input logic [3:0] s);
        int n;
        logic [31:0] r;
        logic [15:0] ln;
        ln = {{8{s[1]}}, {8{s[0]}}} & wmask(i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, seed[1:0]};
        sel <= s;
        dat <= {seed[31:16], d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        r = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk(n, 2);
        if (w && i < 64) m[i[5:0]] = (m[i[5:0]] & ~ln) | (d & ln);
        if (!w) chk(r, {16'h0000, expv(i)});
        if (!w && i == `IDX_INSERT_STATUS) stat = 2'h0;
        @(posedge clk);
    endtask

    // Control outputs against the model.
    task automatic outs();
        chk({b4, b3}, m[`IDX_PID_OUT_S2_B34]);
        chk({lay, l1}, m[`IDX_MODE_LINE_ONE][11:0]);
        chk(l2, m[`IDX_LINE_TWO_SEL][10:0]);
        chk(l3, m[`IDX_LINE_THREE_SEL][10:0]);
        chk({r1, s1, c1}, {m[`IDX_LINE_ONE_PLACE][15:14], m[`IDX_LINE_ONE_PLACE][9:0]});
        chk({r2, s2, c2}, {m[`IDX_LINE_TWO_PLACE][15:14], m[`IDX_LINE_TWO_PLACE][9:0]});
        chk({r3, s3, c3}, {m[`IDX_LINE_THREE_PLACE][15:14], m[`IDX_LINE_THREE_PLACE][9:0]});
        chk(irq, |(stat & m[`IDX_IRQ_MASK][1:0]));
    endtask

    // One-cycle event pulses; the status bits stay until read.
    task automatic pulse(input logic [1:0] b);
        inc <= b[1];
        col <= b[0];
        @(posedge clk);
        inc <= 1'b0;
        col <= 1'b0;
        stat = stat | b;
        @(posedge clk);
        outs();
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // A hang is cut short well past the expected few thousand cycles.
    initial begin
        #200000;
        err_count++;
        summarize();
    end

    // Main sequence: reset values, random traffic, interrupt, second reset.
    initial begin
        {resetn, cyc, stb, we, inc, col, adr, sel, dat, fl, al, lw, aw} = '0;
        seed = 32'h137e737d;
        stat = 2'h0;
        err_count = 0;
        tests_run = 0;
        for (j = 0; j < 8; j++) pa[j] = 8'h00;
        for (j = 0; j < 64; j++) m[j] = 16'h0000;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        for (k = 0; k < 64; k++) wb(1'b0, k, 16'h0000, 4'hF);
        wb(1'b0, 10'h3FF, 16'h0000, 4'hF);
        outs();
        for (k = 0; k < 400; k++) begin
            v = rnd();
            if (v[3:0] == 4'h0) begin
                for (j = 0; j < 8; j++) pa[j] <= rnd();
                {fl, lw} <= rnd();
                {aw, al} <= rnd();
            end
            wb(v[4], v[5] ? wl[v[2:0]] : v[21:16], rnd(), v[11:8] | {2'b00, {2{v[6]}}});
            if (v[13:12] == 2'b11) pulse(v[15:14]);
            outs();
        end
        wb(1'b1, `IDX_IRQ_MASK, 16'h0002, 4'h3);
        wb(1'b0, `IDX_INSERT_STATUS, 16'h0000, 4'hF);
        pulse(2'b01);
        pulse(2'b10);
        wb(1'b0, `IDX_INSERT_STATUS, 16'h0000, 4'hF);
        // Events at the take and clear edges survive a read.
        for (j = 0; j < 2; j++) begin
            fork
                wb(1'b0, `IDX_INSERT_STATUS, 16'h0000, 4'hF);
                begin
                    repeat (j) @(posedge clk);
                    inc <= 1'b1;
                    @(posedge clk);
                    inc <= 1'b0;
                end
            join
            stat = 2'b10;
            wb(1'b0, `IDX_INSERT_STATUS, 16'h0000, 4'hF);
        end
        outs();
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        stat = 2'h0;
        for (j = 0; j < 64; j++) m[j] = 16'h0000;
        repeat (3) @(posedge clk);
        outs();
        summarize();
    end
endmodule // anc_insert_and_format_status_regs_tb_top
